// File: src/dds_pkg.sv
// Purpose: shared constants and types for the drive data select block
// Assumes: one 250 MHz clock domain, 3-bit select value
// Notes:   all widths and limits fixed at the documented values
package dds_pkg;

  // ---------------------------------------------------------------
  // value layout
  // ---------------------------------------------------------------
  localparam int DDS_W = 3;
  localparam int DDS_BIT0_POS = 0;
  localparam int DDS_BIT1_POS = 1;
  localparam int DDS_BIT2_POS = 2;
  localparam logic [2:0] DDS_FACTORY = 3'h0;
  localparam logic [2:0] DDS_TORQUE_MAX = 3'h3;
  localparam logic [2:0] DDS_PUSH_MAX = 3'h7;

  // ---------------------------------------------------------------
  // timing
  // ---------------------------------------------------------------
  localparam int DDS_CLK_PERIOD_NS = 4;
  localparam int DDS_WRITE_LATENCY = 1;

  // ---------------------------------------------------------------
  // control states
  // ---------------------------------------------------------------
  typedef enum logic [1:0] {
    DDS_ST_LOAD = 2'b01,
    DDS_ST_RUN  = 2'b10
  } dds_state_t;

  // ---------------------------------------------------------------
  // helpers
  // ---------------------------------------------------------------
  // push-motion accepts the full range, torque limiting only 0..3
  function automatic logic dds_in_range(input logic [2:0] value, input logic push_mode);
    dds_in_range = push_mode ? (value <= DDS_PUSH_MAX) : (value <= DDS_TORQUE_MAX);
  endfunction

  // torque limiting never drives the top select output
  function automatic logic [2:0] dds_pins(input logic [2:0] value, input logic push_mode);
    dds_pins = push_mode ? value : {1'b0, value[DDS_BIT1_POS:DDS_BIT0_POS]};
  endfunction

endpackage

// File: src/dds_wr_arb.sv
// Purpose: picks one of three write sources and checks its range
// Assumes: all sources are logic on the same clock, no synchronising
// Notes:   fixed priority immediate, then sequence, then fieldbus
`timescale 1ns/1ps
`default_nettype none
module dds_wr_arb
  import dds_pkg::*;
(
  input wire logic imm_wr_in,
  input wire logic [2:0] imm_data_in,
  input wire logic seq_wr_in,
  input wire logic [2:0] seq_data_in,
  input wire logic can_wr_in,
  input wire logic [2:0] can_data_in,
  input wire logic push_mode_in,
  output logic wr_out,
  output logic [2:0] data_out,
  output logic ok_out,
  output logic lost_out
);

  // ---------------------------------------------------------------
  // source selection
  // ---------------------------------------------------------------
  always_comb begin
    wr_out = imm_wr_in | seq_wr_in | can_wr_in;
    data_out = DDS_FACTORY;
    if (imm_wr_in) begin
      data_out = imm_data_in;
    end else if (seq_wr_in) begin
      data_out = seq_data_in;
    end else if (can_wr_in) begin
      data_out = can_data_in;
    end
    ok_out = wr_out & dds_in_range(data_out, push_mode_in);
    // a lower-priority write in the same cycle is dropped, reported as lost
    lost_out = (imm_wr_in & (seq_wr_in | can_wr_in)) | (seq_wr_in & can_wr_in);
  end

endmodule // dds_wr_arb
`default_nettype wire

// File: src/dds_select.sv
// Overview of operation
// - accept 0..3 in torque limiting mode, 0..7 in push-motion mode
// - at power-up load the saved value, or 0 if none saved
// - writes reach outputs at once; only a save command makes them persistent
// - value read and written from immediate, sequence and fieldbus ports; here those ports only write, the value is read on drive_data_select_out
// - torque limiting drives only select bits zero and one
// - push-motion drives select bits zero through two
// - outputs show the value in plain binary, bit two most significant
// - limiting function active only while its enable parameter is 1
//
// Purpose: holds the drive data select value and drives the select pins
// Assumes: nonvolatile store presents its saved value on plain ports
// Notes:   writes are refused until the power-up restore has completed
`timescale 1ns/1ps
`default_nettype none
module dds_select
  import dds_pkg::*;
(
  input wire logic clk_in,
  input wire logic rst_b_in,
  input wire logic ce_in,
  input wire logic imm_wr_in,
  input wire logic [2:0] imm_data_in,
  input wire logic seq_wr_in,
  input wire logic [2:0] seq_data_in,
  input wire logic can_wr_in,
  input wire logic [2:0] can_data_in,
  input wire logic push_mode_in,
  input wire logic limit_function_enable_in,
  input wire logic save_parameters_cmd_in,
  input wire logic nv_ready_in,
  input wire logic nv_saved_in,
  input wire logic [2:0] nv_value_in,
  output logic [2:0] drive_data_select_out,
  output logic drive_select_bit0_out,
  output logic drive_select_bit1_out,
  output logic drive_select_bit2_out,
  output logic limit_active_out,
  output logic ready_out,
  output logic write_err_out,
  output logic nv_save_out,
  output logic [2:0] nv_save_data_out
);

  // ---------------------------------------------------------------
  // write source arbitration
  // ---------------------------------------------------------------
  logic arb_wr;
  logic [2:0] arb_data;
  logic arb_ok;
  logic arb_lost;

  dds_wr_arb u_arb (
    .imm_wr_in(imm_wr_in),
    .imm_data_in(imm_data_in),
    .seq_wr_in(seq_wr_in),
    .seq_data_in(seq_data_in),
    .can_wr_in(can_wr_in),
    .can_data_in(can_data_in),
    .push_mode_in(push_mode_in),
    .wr_out(arb_wr),
    .data_out(arb_data),
    .ok_out(arb_ok),
    .lost_out(arb_lost)
  );

  // ---------------------------------------------------------------
  // value and control state
  // ---------------------------------------------------------------
  dds_state_t state;
  dds_state_t next_state;
  logic [2:0] value;
  logic [2:0] next_value;
  logic [2:0] pins;
  logic [2:0] next_pins;
  logic limit_active;
  logic next_limit_active;
  logic write_err;
  logic next_write_err;
  logic nv_save;
  logic next_nv_save;
  logic [2:0] nv_save_data;
  logic [2:0] next_nv_save_data;
  logic accept;

  always_comb begin
    next_state = state;
    next_value = value;
    next_write_err = 1'b0;
    next_nv_save = 1'b0;
    next_nv_save_data = nv_save_data;
    accept = 1'b0;
    case (state)
      DDS_ST_LOAD: begin
        // restore waits for the store; the catch is clocked, after reset release
        if (nv_ready_in) begin
          next_value = nv_saved_in ? nv_value_in : DDS_FACTORY;
          next_state = DDS_ST_RUN;
        end
        next_write_err = arb_wr;
      end
      DDS_ST_RUN: begin
        accept = arb_ok;
        if (accept) begin
          next_value = arb_data;
        end
        // out-of-range writes leave the value untouched and flag an error
        next_write_err = (arb_wr & ~arb_ok) | arb_lost;
        // a save in the write cycle stores the freshly written value
        if (save_parameters_cmd_in) begin
          next_nv_save = 1'b1;
          next_nv_save_data = next_value;
        end
      end
      default: begin
        next_state = DDS_ST_LOAD;
        next_value = DDS_FACTORY;
      end
    endcase
    next_pins = dds_pins(next_value, push_mode_in);
    next_limit_active = limit_function_enable_in & (state == DDS_ST_RUN);
  end

  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      state <= DDS_ST_LOAD;
      value <= DDS_FACTORY;
      pins <= 3'h0;
      limit_active <= 1'b0;
      write_err <= 1'b0;
      nv_save <= 1'b0;
      nv_save_data <= DDS_FACTORY;
    end else if (ce_in) begin
      state <= next_state;
      value <= next_value;
      pins <= next_pins;
      limit_active <= next_limit_active;
      write_err <= next_write_err;
      nv_save <= next_nv_save;
      nv_save_data <= next_nv_save_data;
    end
  end

  // ---------------------------------------------------------------
  // outputs
  // ---------------------------------------------------------------
  assign drive_data_select_out = value;
  assign drive_select_bit0_out = pins[DDS_BIT0_POS];
  assign drive_select_bit1_out = pins[DDS_BIT1_POS];
  assign drive_select_bit2_out = pins[DDS_BIT2_POS];
  assign limit_active_out = limit_active;
  assign ready_out = state[1];
  assign write_err_out = write_err;
  assign nv_save_out = nv_save;
  assign nv_save_data_out = nv_save_data;

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  range_accept_a: assert property (
    @(posedge clk_in) disable iff (!rst_b_in)
    ce_in && ready_out && arb_wr && !dds_in_range(arb_data, push_mode_in)
    |=> $stable(drive_data_select_out) && write_err_out
  ) else $error("out-of-range write changed the value");

  restore_load_a: assert property (
    @(posedge clk_in) disable iff (!rst_b_in)
    ce_in && !ready_out && nv_ready_in
    |=> ready_out
    && drive_data_select_out == ($past(nv_saved_in) ? $past(nv_value_in) : DDS_FACTORY)
  ) else $error("power-up restore loaded the wrong value");

  write_now_a: assert property (
    @(posedge clk_in) disable iff (!rst_b_in)
    ce_in && ready_out && arb_ok
    |=> drive_data_select_out == $past(arb_data)
  ) else $error("accepted write did not take effect next cycle");

  save_data_a: assert property (
    @(posedge clk_in) disable iff (!rst_b_in)
    ce_in && ready_out && save_parameters_cmd_in
    |=> nv_save_out && nv_save_data_out == drive_data_select_out
  ) else $error("save did not carry the current value");

  imm_first_a: assert property (
    @(posedge clk_in) disable iff (!rst_b_in)
    ce_in && ready_out && imm_wr_in && dds_in_range(imm_data_in, push_mode_in)
    |=> drive_data_select_out == $past(imm_data_in)
  ) else $error("immediate write lost priority");

  torque_pins_a: assert property (
    @(posedge clk_in) disable iff (!rst_b_in)
    ce_in && !push_mode_in |=> !drive_select_bit2_out
  ) else $error("top select output driven in torque limiting");

  push_pins_a: assert property (
    @(posedge clk_in) disable iff (!rst_b_in)
    ce_in && push_mode_in |=> {drive_select_bit2_out, drive_select_bit1_out,
      drive_select_bit0_out} == drive_data_select_out
  ) else $error("select outputs do not match the value");

  limit_gate_a: assert property (
    @(posedge clk_in) disable iff (!rst_b_in)
    ce_in && !limit_function_enable_in |=> !limit_active_out
  ) else $error("limiting active without its enable");

  steady_pins_a: assert property (
    @(posedge clk_in) disable iff (!rst_b_in)
    // pins sampled now came from the previous edge, so that edge must have been enabled
    ce_in && $past(ce_in) && ready_out && !arb_wr && $stable(push_mode_in)
    |=> $stable({drive_select_bit2_out, drive_select_bit1_out, drive_select_bit0_out})
  ) else $error("select outputs changed without a write");

  freeze_a: assert property (
    @(posedge clk_in) disable iff (!rst_b_in)
    !ce_in |=> $stable(drive_data_select_out) && $stable(ready_out)
  ) else $error("state moved while clock enable low");

endmodule // dds_select
`default_nettype wire

// File: verification/dds_drv_model.sv
// Purpose: far side: motor driver select inputs plus parameter store
// Assumes: store write lands on the clock after the save pulse
// Notes: store starts blank holding a stale nonzero value
`timescale 1ns/1ps
`default_nettype none
module dds_drv_model (
  input wire logic clk_in,
  input wire logic sel0_in,
  input wire logic sel1_in,
  input wire logic sel2_in,
  input wire logic nv_save_in,
  input wire logic [2:0] nv_save_data_in,
  output logic [2:0] code_out,
  output logic nv_saved_out,
  output logic [2:0] nv_value_out
);
  // stale value catches a restore that ignores the saved flag
  initial begin
    nv_saved_out = 1'b0;
    nv_value_out = 3'h5;
  end
  assign code_out = {sel2_in, sel1_in, sel0_in};
  always @(posedge clk_in) begin
    if (nv_save_in) begin
      nv_saved_out <= 1'b1;
      nv_value_out <= nv_save_data_in;
    end
  end
endmodule // dds_drv_model
`default_nettype wire

// File: verification/drive_data_select_outputs_test.sv
// Purpose: self-checking bench for the select block
// Assumes: inputs change 1 ns after the rising edge
// Notes: expectations queued by drivers, checked at falling edge
`timescale 1ns/1ps
`default_nettype none
module drive_data_select_outputs_test;
  import dds_pkg::*;
  logic clk_in, rst_b_in, ce_in, iw, sw, cw, pm, le, sc, nr, ns;
  logic [2:0] id, sd, cd, val, code, nv, dd, exp_v, sv_exp;
  logic b0, b1, b2, la, rdy, we, nsv, rdy_exp;
  logic [4:0] q[$];
  logic [4:0] nt;
  int n_errors = 0, checked = 0, cyc = 0, seed = 32'h85cc, r;

  dds_select dut (.clk_in(clk_in), .rst_b_in(rst_b_in), .ce_in(ce_in),
    .imm_wr_in(iw), .imm_data_in(id), .seq_wr_in(sw), .seq_data_in(sd),
    .can_wr_in(cw), .can_data_in(cd), .push_mode_in(pm),
    .limit_function_enable_in(le), .save_parameters_cmd_in(sc),
    .nv_ready_in(nr), .nv_saved_in(ns), .nv_value_in(nv),
    .drive_data_select_out(val), .drive_select_bit0_out(b0),
    .drive_select_bit1_out(b1), .drive_select_bit2_out(b2),
    .limit_active_out(la), .ready_out(rdy), .write_err_out(we),
    .nv_save_out(nsv), .nv_save_data_out(dd));
  dds_drv_model far (.clk_in(clk_in), .sel0_in(b0), .sel1_in(b1),
    .sel2_in(b2), .nv_save_in(nsv), .nv_save_data_in(dd),
    .code_out(code), .nv_saved_out(ns), .nv_value_out(nv));

  initial begin
    clk_in = 1'b0;
    forever #2 clk_in = ~clk_in;
  end

  task report_and_stop;
    if (n_errors == 0 && checked > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask

  task chk(input logic [3:0] got, input logic [3:0] exp);
    checked++;
    if (got !== exp) begin
      n_errors++;
      $display("[ERR] %0t got %h want %h", $time, got, exp);
    end
  endtask

  task tick;
    @(posedge clk_in);
    #1;
  endtask

  task note(input logic e);
    q.push_back({e, pm, exp_v});
  endtask

  // -------------------------------------------------
  // one write; other sources carry decoy data
  // -------------------------------------------------
  task wr(input int s, input logic [2:0] d, input logic p);
    logic ok;
    pm = p;
    {iw, sw, cw} = {s == 0, s == 1, s == 2};
    id = (s == 0) ? d : ~d;
    sd = (s == 1) ? d : ~d;
    cd = (s == 2) ? d : ~d;
    ok = rdy_exp && (d <= (p ? DDS_PUSH_MAX : DDS_TORQUE_MAX));
    tick;
    // strobes stay up so a following write raises nothing twice in one step
    if (ok) exp_v = d;
    note(!ok);
  endtask

  task restore;
    rst_b_in = 1'b0;
    nr = 1'b0;
    rdy_exp = 1'b0;
    exp_v = 3'h0;
    repeat (8) tick;
    rst_b_in = 1'b1;
    tick;
    wr(0, 3'h1, 1'b1);
    {iw, sw, cw} = 3'h0;
    nr = 1'b1;
    tick;
    exp_v = sv_exp;
    rdy_exp = 1'b1;
    note(1'b0);
    chk(rdy, 1'b1);
  endtask

  always @(negedge clk_in) begin
    if (q.size() > 0) begin
      nt = q.pop_front();
      chk(val, nt[2:0]);
      chk(code, nt[3] ? nt[2:0] : {1'b0, nt[1:0]});
      chk(we, nt[4]);
    end
  end

  always @(posedge clk_in) begin
    cyc++;
    if (cyc == 3000) begin
      n_errors++;
      report_and_stop;
    end
  end

  initial begin
    {ce_in, iw, sw, cw, pm, le, sc} = 7'h40;
    {id, sd, cd, sv_exp} = 12'h000;
    restore;
    le = 1'b1;
    tick;
    chk(la, 1'b1);
    le = 1'b0;
    tick;
    chk(la, 1'b0);
    for (int i = 0; i < 8; i++) wr(i % 3, i[2:0], 1'b1);
    for (int i = 0; i < 8; i++) wr(i % 3, i[2:0], 1'b0);
    wr(0, 3'h7, 1'b1);
    {iw, sw, cw, pm} = 4'h0;
    tick;
    note(1'b0);
    repeat (40) begin
      r = $random(seed);
      wr(int'(r[1:0]) % 3, r[4:2], r[5]);
    end
    {iw, sw, cw, pm} = 4'hf;
    {id, sd, cd} = 9'o256;
    tick;
    {iw, sw, cw} = 3'h0;
    exp_v = 3'h2;
    note(1'b1);
    repeat (3) begin
      tick;
      note(1'b0);
    end
    {ce_in, iw, id} = 5'h0c;
    tick;
    ce_in = 1'b1;
    note(1'b0);
    sc = 1'b1;
    wr(1, 3'h6, 1'b1);
    sc = 1'b0;
    sv_exp = 3'h6;
    wr(2, 3'h2, 1'b1);
    {iw, sw, cw} = 3'h0;
    tick;
    chk(nv, 3'h6);
    restore;
    repeat (2) tick;
    report_and_stop;
  end
endmodule // drive_data_select_outputs_test
`default_nettype wire
